// >>> hw/txcd_decoder.sv
// Top: decodes transmit buffer command words and extracts frame data
`timescale 1ns/1ps
//
// Contract
// RULE1: Command A bits 17:16 give start offset
// RULE2: Command A bit 13 marks frame start
// RULE3: Command A bit 12 marks frame end
// RULE4: Command A bits 10:0 give buffer bytes
// RULE5: Trailing pad bytes are never forwarded
// RULE6: Buffer sizes summed per frame, restarted
// RULE7: Sum unequal to frame length raises error
// RULE8: Host excludes offset and pad from size
// RULE9: Checksum needs request, first segment, enable
// RULE10: Host sets checksum request in first buffer
// RULE11: Command B bits 10:0 give frame length
// RULE12: Command B differing across frame raises error
// RULE13: Error flag goes to status and endpoint
// RULE14: Payload starts at third buffer word
// RULE15: Reserved command bits are ignored
module txcd_decoder
   import txcd_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rstn_i,
   input  wire logic [31:0] fifo_data_i,
   input  wire logic        fifo_valid_i,
   output logic             fifo_ready_o,
   input  wire logic        tx_checksum_engine_enable_i,
   output logic [31:0]      tli_data_o,
   output logic [3:0]       tli_be_o,
   output logic             tli_sof_o,
   output logic             tli_eof_o,
   output logic             tli_csum_o,
   output logic             tli_valid_o,
   input  wire logic        tli_ready_i,
   output logic             transmitter_error_flag_o,
   output logic             int_sts_txe_o,
   output logic             int_ep_txe_o
);
   ////////////////////////////////////////////////////////////////////////////
   txcd_stream_if dec_s ();
   txcd_stream_if tli_s ();

   txcd_state_t state_ff, nxt_state;
   logic [1:0]  ofs_ff, nxt_ofs;
   logic        first_ff, nxt_first;
   logic        last_ff, nxt_last;
   logic [11:0] left_ff, nxt_left;
   logic [11:0] sum_ff, nxt_sum;
   logic [31:0] cmdb_ff, nxt_cmdb;
   logic        in_frame_ff, nxt_in_frame;
   logic        ck_ff, nxt_ck;
   logic        dword_first_ff, nxt_dword_first;
   logic        err_ff, nxt_err;
   logic [11:0] frame_len;
   logic [11:0] avail;
   logic [11:0] take;
   logic [3:0]  be_lo, be_hi;
   logic        take_word;
   logic        mismatch_b;
   logic        bad_a;
   logic        size_zero;
   logic        first_missing;
   logic        first_extra;

   // Payload words are held off while the buffer is full, and all input for good after an error
   assign take_word    = fifo_valid_i && fifo_ready_o;
   assign fifo_ready_o = (state_ff == TXCD_ST_DATA) ? dec_s.ready : (state_ff != TXCD_ST_ERR);

   ////////////////////////////////////////////////////////////////////////////
   // Byte lanes of one payload word
   always_comb begin
      logic [2:0] lo;
      // First word starts at the offset lane, later words at lane 0
      lo    = dword_first_ff ? {1'b0, ofs_ff} : 3'h0;                        // RULE1
      avail = 12'(3'h4 - lo);
      take  = (left_ff < avail) ? left_ff : avail;
      be_lo = TXCD_BE_ALL << lo[1:0];
      // Lanes above the last counted byte are pad and stay disabled
      be_hi = TXCD_BE_ALL >> (3'h4 - 3'(lo + take[2:0]));                    // RULE5
      if (lo + take[2:0] == 3'h4) begin
         be_hi = TXCD_BE_ALL;
      end
   end

   assign dec_s.valid = (state_ff == TXCD_ST_DATA) && fifo_valid_i;
   assign dec_s.data  = fifo_data_i;
   assign dec_s.be    = be_lo & be_hi;
   assign dec_s.sof   = dword_first_ff && first_ff;                          // RULE2
   assign dec_s.eof   = (left_ff <= avail) && last_ff;                       // RULE3
   assign dec_s.ck    = ck_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Command checks; reserved bits never enter a comparison
   // Command B bits 13:12 must match as well, bits 31:15 and 11 are reserved
   assign frame_len  = {1'b0, fifo_data_i[TXCD_B_LEN_HI:0]};                 // RULE11
   assign mismatch_b = in_frame_ff &&
                       ((fifo_data_i & TXCD_B_CMP_MASK) != (cmdb_ff & TXCD_B_CMP_MASK)); // RULE12 RULE15
   // Command A faults: empty buffer, or a first flag at odds with the frame state
   assign size_zero     = (fifo_data_i[TXCD_A_SIZE_HI:0] == TXCD_LEN_ZERO);          // RULE4
   assign first_missing = !in_frame_ff && !fifo_data_i[TXCD_A_FIRST_BIT];             // RULE2
   assign first_extra   = in_frame_ff && fifo_data_i[TXCD_A_FIRST_BIT];               // RULE2
   assign bad_a         = size_zero || first_missing || first_extra;

   always_comb begin
      logic [11:0] sum_new;
      logic        b_differs, len_wrong, len_early;
      nxt_state       = state_ff;
      nxt_ofs         = ofs_ff;
      nxt_first       = first_ff;
      nxt_last        = last_ff;
      nxt_left        = left_ff;
      nxt_sum         = sum_ff;
      nxt_cmdb        = cmdb_ff;
      nxt_in_frame    = in_frame_ff;
      nxt_ck          = ck_ff;
      nxt_dword_first = dword_first_ff;
      nxt_err         = err_ff;
      sum_new         = 12'(sum_ff + left_ff);
      b_differs       = 1'b0;
      len_wrong       = 1'b0;
      len_early       = 1'b0;
      unique case (state_ff)
         TXCD_ST_CMDA: if (take_word) begin
            nxt_ofs   = fifo_data_i[TXCD_A_OFS_HI:TXCD_A_OFS_LO];                 // RULE1
            nxt_first = fifo_data_i[TXCD_A_FIRST_BIT];                            // RULE2
            nxt_last  = fifo_data_i[TXCD_A_LAST_BIT];                             // RULE3
            nxt_left  = {1'b0, fifo_data_i[TXCD_A_SIZE_HI:0]};                    // RULE4 RULE8
            // A new frame restarts the running total
            if (fifo_data_i[TXCD_A_FIRST_BIT]) begin
               nxt_sum = TXCD_SUM_ZERO;                                           // RULE6
            end
            nxt_state = bad_a ? TXCD_ST_ERR : TXCD_ST_CMDB;
            nxt_err   = bad_a;
         end
         TXCD_ST_CMDB: if (take_word) begin
            sum_new = 12'(sum_ff + left_ff);                                      // RULE6
            if (first_ff) begin
               nxt_cmdb = fifo_data_i;
               // Checksum request honoured only on the opening buffer
               nxt_ck   = fifo_data_i[TXCD_B_CKREQ_BIT] && tx_checksum_engine_enable_i; // RULE9 RULE10
            end
            nxt_sum         = sum_new;
            nxt_dword_first = 1'b1;
            nxt_in_frame    = !last_ff;
            b_differs = !first_ff && mismatch_b;                                  // RULE12
            len_wrong = last_ff && (sum_new != frame_len);                        // RULE7
            // Total already reached without a last flag: the frame overruns
            len_early = !last_ff && (sum_new >= frame_len);                       // RULE7
            if (b_differs || len_wrong || len_early) begin
               nxt_err   = 1'b1;
               nxt_state = TXCD_ST_ERR;
            end else begin
               nxt_state = TXCD_ST_DATA;                                          // RULE14
            end
         end
         TXCD_ST_DATA: if (take_word) begin
            nxt_dword_first = 1'b0;
            nxt_left        = left_ff - take;                                     // RULE5
            // Remaining count fits the lanes left: last word of the buffer
            if (left_ff <= avail) begin
               nxt_state = TXCD_ST_CMDA;
            end
         end
         TXCD_ST_ERR: begin
            // Path is out of sync; only a reset recovers
            nxt_state = TXCD_ST_ERR;
         end
      endcase
   end

   // Decoder state; reset returns it to waiting for a command A
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_ff       <= TXCD_ST_CMDA;
         ofs_ff         <= 2'h0;
         first_ff       <= 1'b0;
         last_ff        <= 1'b0;
         left_ff        <= TXCD_SUM_ZERO;
         sum_ff         <= TXCD_SUM_ZERO;
         cmdb_ff        <= TXCD_WORD_ZERO;
         in_frame_ff    <= 1'b0;
         ck_ff          <= 1'b0;
         dword_first_ff <= 1'b0;
         err_ff         <= 1'b0;
      end else begin
         state_ff       <= nxt_state;
         ofs_ff         <= nxt_ofs;
         first_ff       <= nxt_first;
         last_ff        <= nxt_last;
         left_ff        <= nxt_left;
         sum_ff         <= nxt_sum;
         cmdb_ff        <= nxt_cmdb;
         in_frame_ff    <= nxt_in_frame;
         ck_ff          <= nxt_ck;
         dword_first_ff <= nxt_dword_first;
         err_ff         <= nxt_err;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One sticky flag feeds both host-visible copies
   assign transmitter_error_flag_o = err_ff;
   assign int_sts_txe_o            = err_ff;                                 // RULE13
   assign int_ep_txe_o             = err_ff;                                 // RULE13

   // The buffer absorbs a receiver stall without losing a word
   txcd_skid_buf u_buf (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      .in_s    (dec_s),
      .out_s   (tli_s)
   );

   assign tli_valid_o = tli_s.valid;
   assign tli_data_o  = tli_s.data;
   assign tli_be_o    = tli_s.be;
   assign tli_sof_o   = tli_s.sof;
   assign tli_eof_o   = tli_s.eof;
   assign tli_csum_o  = tli_s.ck;
   assign tli_s.ready = tli_ready_i;
endmodule

// >>> hw/txcd_pkg.sv
// Package: field layout and constants of the transmit buffer command decoder
package txcd_pkg;
   localparam int          TXCD_DW            = 32;
   localparam int          TXCD_LEN_W         = 11;
   // Command word A fields
   localparam int          TXCD_A_OFS_HI      = 17;
   localparam int          TXCD_A_OFS_LO      = 16;
   localparam int          TXCD_A_FIRST_BIT   = 13;
   localparam int          TXCD_A_LAST_BIT    = 12;
   localparam int          TXCD_A_SIZE_HI     = 10;
   // Command word B fields
   localparam int          TXCD_B_CKREQ_BIT   = 14;
   localparam int          TXCD_B_LEN_HI      = 10;
   // Command B compare: length and the two control bits; checksum request and reserved excluded
   localparam logic [31:0] TXCD_B_CMP_MASK    = 32'h000037FF;
   localparam logic [10:0] TXCD_LEN_ZERO      = 11'h000;
   localparam logic [11:0] TXCD_SUM_ZERO      = 12'h000;
   localparam logic [3:0]  TXCD_BE_ALL        = 4'hF;
   localparam logic [3:0]  TXCD_BE_NONE       = 4'h0;
   localparam logic [31:0] TXCD_WORD_ZERO     = 32'h00000000;

   typedef enum logic [1:0] {
      TXCD_ST_CMDA,
      TXCD_ST_CMDB,
      TXCD_ST_DATA,
      TXCD_ST_ERR
   } txcd_state_t;
endpackage

// >>> hw/txcd_stream_if.sv
// Interface: word stream with byte enables and frame markers
`timescale 1ns/1ps
interface txcd_stream_if;
   logic        valid;
   logic        ready;
   logic [31:0] data;
   logic [3:0]  be;
   logic        sof;
   logic        eof;
   logic        ck;
   modport src (output valid, output data, output be, output sof, output eof, output ck,
                input ready);
   modport snk (input valid, input data, input be, input sof, input eof, input ck,
                output ready);
endinterface

// >>> hw/txcd_skid_buf.sv
// Two-entry buffer between the decoder and the Ethernet transmit layer
`timescale 1ns/1ps
module txcd_skid_buf (
   input  wire logic clock_i,
   input  wire logic rstn_i,
   txcd_stream_if.snk in_s,
   txcd_stream_if.src out_s
);
   localparam int W = 39;
   logic [W-1:0] mem_ff [2];
   logic [W-1:0] nxt_mem [2];
   logic         wp_ff, nxt_wp, rp_ff, nxt_rp;
   logic [1:0]   cnt_ff, nxt_cnt;
   logic         push, pop;

   assign in_s.ready  = (cnt_ff != 2'h2);
   assign out_s.valid = (cnt_ff != 2'h0);
   assign push        = in_s.valid && in_s.ready;
   assign pop         = out_s.valid && out_s.ready;
   assign {out_s.data, out_s.be, out_s.sof, out_s.eof, out_s.ck} = mem_ff[rp_ff];

   always_comb begin
      nxt_mem = mem_ff;
      nxt_wp  = wp_ff;
      nxt_rp  = rp_ff;
      nxt_cnt = cnt_ff;
      if (push) begin
         nxt_mem[wp_ff] = {in_s.data, in_s.be, in_s.sof, in_s.eof, in_s.ck};
         nxt_wp         = ~wp_ff;
      end
      if (pop) begin
         nxt_rp = ~rp_ff;
      end
      if (push && !pop) begin
         nxt_cnt = cnt_ff + 2'h1;
      end else if (pop && !push) begin
         nxt_cnt = cnt_ff - 2'h1;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mem_ff[0] <= '0;
         mem_ff[1] <= '0;
         wp_ff     <= 1'b0;
         rp_ff     <= 1'b0;
         cnt_ff    <= 2'h0;
      end else begin
         mem_ff <= nxt_mem;
         wp_ff  <= nxt_wp;
         rp_ff  <= nxt_rp;
         cnt_ff <= nxt_cnt;
      end
   end
endmodule

// >>> verification/txcd_decoder_props.sv
// Checker: concurrent properties on the decoder's top-level ports
`timescale 1ns/1ps
module txcd_decoder_props
   import txcd_pkg::*;
(
   input wire logic        clock_i,
   input wire logic        rstn_i,
   input wire logic [31:0] fifo_data_i,
   input wire logic        fifo_valid_i,
   input wire logic        fifo_ready_o,
   input wire logic        tx_checksum_engine_enable_i,
   input wire logic [31:0] tli_data_o,
   input wire logic [3:0]  tli_be_o,
   input wire logic        tli_sof_o,
   input wire logic        tli_eof_o,
   input wire logic        tli_csum_o,
   input wire logic        tli_valid_o,
   input wire logic        tli_ready_i,
   input wire logic        transmitter_error_flag_o,
   input wire logic        int_sts_txe_o,
   input wire logic        int_ep_txe_o
);
   logic in_frame_ff;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   sequence s_wait; tli_valid_o && !tli_ready_i; endsequence
   sequence s_last_beat; tli_valid_o && tli_ready_i ##0 tli_eof_o; endsequence
   ////////////////////////////////////////////////////////////////////////
   // Frame tracker: a beat opens a frame unless it also closes it
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         in_frame_ff <= 1'b0;
      end else if (tli_valid_o && tli_ready_i) begin
         in_frame_ff <= !tli_eof_o;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   a_err_copies_agree: assert property (int_sts_txe_o == transmitter_error_flag_o
      && int_ep_txe_o == transmitter_error_flag_o) else $error("error copies differ");
   a_err_stays_set: assert property (transmitter_error_flag_o |=> transmitter_error_flag_o)
      else $error("error flag dropped");
   a_err_stalls_input: assert property (transmitter_error_flag_o |-> !fifo_ready_o)
      else $error("input taken after error");
   a_err_has_cause: assert property ($rose(transmitter_error_flag_o) |->
      $past(fifo_valid_i) && $past(fifo_ready_o)) else $error("error without word");
   a_beat_held: assert property (s_wait |=> tli_valid_o && $stable(tli_data_o)
      && $stable(tli_be_o) && $stable(tli_eof_o)) else $error("beat changed in stall");
   a_lanes_used: assert property (tli_valid_o |-> tli_be_o != TXCD_BE_NONE)
      else $error("beat with no lanes");
   a_sof_opens: assert property (tli_valid_o |-> tli_sof_o == !in_frame_ff)
      else $error("start marker misplaced");
   a_eof_closes: assert property (s_last_beat |=> !tli_valid_o || tli_sof_o)
      else $error("frame not reopened");
   a_csum_gated: assert property (tli_valid_o && tli_csum_o |->
      tx_checksum_engine_enable_i) else $error("checksum without enable");
endmodule

// >>> verification/txcd_host_model.sv
// Host driver model: offers queued transmit buffer words on the fifo handshake
`timescale 1ns/1ps
module txcd_host_model (
   input  wire logic   clock_i,
   input  wire logic   rstn_i,
   input  wire logic   fifo_ready_i,
   output logic [31:0] fifo_data_o,
   output logic        fifo_valid_o
);
   logic [31:0] q[$];
   initial begin
      fifo_data_o  = 32'h00000000;
      fifo_valid_o = 1'b0;
   end
   // A word leaves the queue only at the edge that saw it accepted
   always @(posedge clock_i) begin
      if (rstn_i && fifo_valid_o && fifo_ready_i && q.size() > 0) begin
         void'(q.pop_front());
      end
   end
   // Idle data toggles so a stale word can never pass for a fresh one
   always @(negedge clock_i) begin
      if (rstn_i && q.size() > 0) begin
         fifo_valid_o <= 1'b1;
         fifo_data_o  <= q[0];
      end else begin
         fifo_valid_o <= 1'b0;
         fifo_data_o  <= ~fifo_data_o;
      end
   end
endmodule

// >>> verification/testbench.sv
// Testbench: buffers pushed through the host model, beats compared with expectations
`timescale 1ns/1ps
module testbench;
   import txcd_pkg::*;
   logic        clock_i, rstn_i, fifo_valid_i, fifo_ready_o, tx_checksum_engine_enable_i;
   logic        tli_sof_o, tli_eof_o, tli_csum_o, tli_valid_o, tli_ready_i, stall_en, exp_ck;
   logic        transmitter_error_flag_o, int_sts_txe_o, int_ep_txe_o;
   logic [31:0] fifo_data_i, tli_data_o;
   logic [3:0]  tli_be_o;
   logic [37:0] exp_q[$];
   int          fail_count, compares, cyc;
   txcd_decoder txcd_decoder_i (.clock_i, .rstn_i, .fifo_data_i, .fifo_valid_i, .fifo_ready_o,
      .tx_checksum_engine_enable_i, .tli_data_o, .tli_be_o, .tli_sof_o, .tli_eof_o,
      .tli_csum_o, .tli_valid_o, .tli_ready_i, .transmitter_error_flag_o, .int_sts_txe_o,
      .int_ep_txe_o);
   txcd_host_model txcd_host_model_i (.clock_i, .rstn_i, .fifo_ready_i(fifo_ready_o),
      .fifo_data_o(fifo_data_i), .fifo_valid_o(fifo_valid_i));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [37:0] e, input logic [37:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic close_out();
      $display("Counts: compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Host encodes size without offset or pad; command A reserved bits come from res, command B ones from b
   task automatic send_buf(input logic [1:0] ofs, input logic fs, input logic ls,
      input logic [10:0] size, input logic ck, input logic [31:0] res, input logic [31:0] b);
      int n;
      logic [3:0] be;
      n = (ofs + size + 3) / 4;
      txcd_host_model_i.q.push_back(res | {14'h0, ofs, 2'h0, fs, ls, 1'h0, size});
      txcd_host_model_i.q.push_back(b | {17'h0, ck, 14'h0});
      for (int i = 0; i < n; i++) begin
         for (int j = 0; j < 4; j++) be[j] = (4 * i + j >= ofs) && (4 * i + j < ofs + size);
         txcd_host_model_i.q.push_back({5'h1A, size, 8'h00, i[7:0]});
         exp_q.push_back({fs && i == 0, ls && i == n - 1, be, 5'h1A, size, 8'h00, i[7:0]});
      end
   endtask
   task automatic drain(input string name);
      for (int k = 0; k < 300 && exp_q.size() + txcd_host_model_i.q.size() > 0; k++) begin
         @(negedge clock_i);
      end
      repeat (4) @(negedge clock_i);
      chk(name, 38'h0, {37'h0, exp_q.size() > 0});
      chk(name, 38'h0, {37'h0, transmitter_error_flag_o});
      $display("Test %s done", name);
   endtask
   task automatic do_reset();
      rstn_i = 1'b0;
      repeat (16) @(negedge clock_i);
      rstn_i = 1'b1;
   endtask
   // An error leaves the flag set and the input held off; only a reset clears it
   task automatic err_case(input string name);
      repeat (20) @(negedge clock_i);
      exp_q.delete();
      txcd_host_model_i.q.delete();
      chk({name, "_txe"}, 38'h1, {37'h0, transmitter_error_flag_o});
      chk({name, "_sts_ep"}, 38'h3, {36'h0, int_sts_txe_o, int_ep_txe_o});
      chk({name, "_ready"}, 38'h0, {37'h0, fifo_ready_o});
      do_reset();
      chk({name, "_rst"}, 38'h0, {37'h0, transmitter_error_flag_o});
      $display("Test %s done", name);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end
   always @(negedge clock_i) tli_ready_i <= !stall_en || cyc[2];
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc > 4000) begin
         fail_count++;
         close_out();
      end
      if (tli_valid_o === 1'b1 && tli_ready_i === 1'b1) begin
         chk("beat", exp_q.size() > 0 ? exp_q.pop_front() : 38'h0,
            {tli_sof_o, tli_eof_o, tli_be_o, tli_data_o});
         if (tli_sof_o === 1'b1) chk("csum", {37'h0, exp_ck}, {37'h0, tli_csum_o});
      end
   end
   initial begin
      {rstn_i, stall_en, exp_ck, tx_checksum_engine_enable_i} = 4'h1;
      {fail_count, compares} = '0;
      do_reset();
      // Single buffer with the receiver stalling; its two payload words fit the buffer without a refusal
      stall_en = 1'b1;
      exp_ck   = 1'b1;
      send_buf(2'h1, 1, 1, 11'h006, 1, 32'h0, 32'h6);
      drain("single");
      // Split frame, reserved bits set, checksum bit only in the first buffer
      send_buf(2'h0, 1, 0, 11'h005, 1, 32'hFFFCC800, 32'h8);
      send_buf(2'h3, 0, 1, 11'h003, 0, 32'h0, 32'h00100008);
      drain("split");
      tx_checksum_engine_enable_i = 1'b0;
      exp_ck = 1'b0;
      send_buf(2'h2, 1, 1, 11'h004, 1, 32'h0, 32'h4);
      drain("noenable");
      // Buffer total short of frame length: error, then input held off
      send_buf(2'h0, 1, 1, 11'h008, 0, 32'h0, 32'hA);
      err_case("error");
      // Command B differs in a control bit between the two buffers of a frame
      send_buf(2'h0, 1, 0, 11'h004, 0, 32'h0, 32'h8);
      send_buf(2'h0, 0, 1, 11'h004, 0, 32'h0, 32'h1008);
      err_case("cmdb_diff");
      // Frame opened without the first flag
      send_buf(2'h1, 0, 1, 11'h004, 0, 32'h0, 32'h4);
      err_case("no_first");
      // Empty buffer
      send_buf(2'h0, 1, 1, 11'h000, 0, 32'h0, 32'h0);
      err_case("size_zero");
      close_out();
   end
endmodule
bind txcd_decoder txcd_decoder_props txcd_decoder_props_i (.clock_i, .rstn_i, .fifo_data_i,
   .fifo_valid_i, .fifo_ready_o, .tx_checksum_engine_enable_i, .tli_data_o, .tli_be_o,
   .tli_sof_o, .tli_eof_o, .tli_csum_o, .tli_valid_o, .tli_ready_i, .transmitter_error_flag_o,
   .int_sts_txe_o, .int_ep_txe_o);
